/* design/udu_consts.svh */
// Constants for the unsigned divide unit
`ifndef UDU_CONSTS_SVH
`define UDU_CONSTS_SVH
`define UDU_DIV_STEPS    7'h40
`define UDU_BYTE_QMAX    32'h000000FF
`define UDU_WORD_QMAX    32'h0000FFFF
`define UDU_ERR_ZERO     16'h0000
`define UDU_CPL_USER     2'h3
`define UDU_FLAGS_RESULT 6'h00
`endif

/* design/udu_pkg.sv */
// Types of the unsigned divide unit
package udu_pkg;
    typedef enum logic [1:0] {UDU_SZ_BYTE, UDU_SZ_WORD, UDU_SZ_DWORD}
        udu_size_t;
    typedef enum logic [1:0] {UDU_MD_REAL, UDU_MD_PROT, UDU_MD_V86}
        udu_mode_t;
    typedef enum logic [2:0] {
        UDU_EX_NONE, UDU_EX_DIVIDE, UDU_EX_GP, UDU_EX_SS, UDU_EX_PF,
        UDU_EX_AC
    } udu_exc_t;
endpackage

/* design/udu_restore_step.sv */
// One restoring division step
`timescale 1ns/1ns
module udu_restore_step (
    input  wire logic [63:0] rem_in,     // Partial remainder
    input  wire logic [63:0] quo_in,     // Dividend bits / quotient so far
    input  wire logic [31:0] dvs_in,     // Divisor
    output logic      [63:0] rem_out,    // Next partial remainder
    output logic      [63:0] quo_out     // Next quotient shift
);
    logic [64:0] shifted;
    logic [64:0] diff;
    always_comb begin
        shifted = {rem_in, quo_in[63]};
        diff    = shifted - {33'h0, dvs_in};
        if (diff[64]) begin
            rem_out = shifted[63:0];
            quo_out = {quo_in[62:0], 1'b0};
        end else begin
            rem_out = diff[63:0];
            quo_out = {quo_in[62:0], 1'b1};
        end
    end
endmodule

/* design/udu_divide_unit.sv */
// Unsigned divide unit: sequential divider with fault checks
`timescale 1ns/1ns
`include "udu_consts.svh"
module udu_divide_unit (
    input  wire logic              SYS_CLK_IN,       // Core clock
    input  wire logic              RST_IN,           // Sync reset, high
    input  wire logic              START_IN,         // Issue pulse
    input  wire udu_pkg::udu_size_t SIZE_IN,         // Operand size
    input  wire udu_pkg::udu_mode_t MODE_IN,         // Operating mode
    input  wire logic              MEM_SRC_IN,       // Divisor from memory
    input  wire logic [31:0]       REG_DVS_IN,       // Register divisor
    input  wire logic [31:0]       MEM_DVS_IN,       // Memory divisor
    input  wire logic [31:0]       ACC_IN,           // Accumulator
    input  wire logic [31:0]       DATA_IN,          // Data register
    input  wire logic              SEG_LIMIT_IN,     // Data seg limit breach
    input  wire logic              NULL_SEL_IN,      // Null selector used
    input  wire logic              STK_LIMIT_IN,     // Stack limit breach
    input  wire logic              PAGE_FAULT_IN,    // Page fault on fetch
    input  wire logic [15:0]       PF_CODE_IN,       // Page fault code
    input  wire logic              UNALIGNED_IN,     // Unaligned reference
    input  wire logic              ALIGN_EN_IN,      // Alignment checking on
    input  wire logic [1:0]        CPL_IN,           // Privilege level
    output logic                   BUSY_OUT,         // Divide in progress
    output logic                   DONE_OUT,         // Result pulse
    output logic                   WR_ACC_OUT,       // Write accumulator
    output logic                   WR_DATA_OUT,      // Write data register
    output logic [31:0]            ACC_OUT,          // Accumulator result
    output logic [31:0]            DATA_OUT,         // Data register result
    output logic [5:0]             FLAGS_OUT,        // Undefined flags
    output udu_pkg::udu_exc_t      EXC_OUT,          // Exception kind
    output logic                   EXC_HAS_CODE_OUT, // Error code valid
    output logic [15:0]            EXC_CODE_OUT      // Error code
);
    typedef enum logic [1:0] {UDU_ST_IDLE, UDU_ST_RUN, UDU_ST_DONE}
        udu_state_t;
    default clocking udu_cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    // ******************************************
    // Operand decode
    // ******************************************
    logic [31:0] divisor;
    logic [63:0] dividend;
    logic [31:0] divisor_q,  divisor_d;
    logic [63:0] rem_q,      rem_d;
    logic [63:0] quo_q,      quo_d;
    logic [6:0]  cnt_q,      cnt_d;
    udu_pkg::udu_size_t size_q, size_d;
    udu_state_t  st_q,       st_d;

    // Mask the divisor to its width so stale upper bits are ignored
    function automatic logic [31:0] size_mask(udu_pkg::udu_size_t s);
        unique case (s)
            udu_pkg::UDU_SZ_BYTE: size_mask = 32'h000000FF;
            udu_pkg::UDU_SZ_WORD: size_mask = 32'h0000FFFF;
            default:              size_mask = 32'hFFFFFFFF;
        endcase
    endfunction

    always_comb begin
        divisor = (MEM_SRC_IN ? MEM_DVS_IN : REG_DVS_IN) & size_mask(SIZE_IN);
        unique case (SIZE_IN)
            udu_pkg::UDU_SZ_BYTE:  dividend = {48'h0, ACC_IN[15:0]};
            udu_pkg::UDU_SZ_WORD:  dividend = {32'h0, DATA_IN[15:0],
                                               ACC_IN[15:0]};
            default:               dividend = {DATA_IN, ACC_IN};
        endcase
    end

    // ******************************************
    // Fault priority
    // ******************************************
    udu_pkg::udu_exc_t exc_now;
    logic              code_now;
    logic [15:0]       code_val;
    logic              prot;
    always_comb begin
        prot     = (MODE_IN != udu_pkg::UDU_MD_REAL);
        exc_now  = udu_pkg::UDU_EX_NONE;
        code_now = 1'b0;
        code_val = `UDU_ERR_ZERO;
        if (MEM_SRC_IN && (SEG_LIMIT_IN ||
                           (MODE_IN == udu_pkg::UDU_MD_PROT &&
                            NULL_SEL_IN) ||
                           (MODE_IN == udu_pkg::UDU_MD_REAL &&
                            NULL_SEL_IN))) begin
            // protection fault, no code in real mode
            exc_now  = udu_pkg::UDU_EX_GP;
            code_now = prot;
        end else if (MEM_SRC_IN && STK_LIMIT_IN) begin
            exc_now  = udu_pkg::UDU_EX_SS;
            code_now = prot;
        end else if (MEM_SRC_IN && PAGE_FAULT_IN && prot) begin
            exc_now  = udu_pkg::UDU_EX_PF;
            code_now = 1'b1;
            code_val = PF_CODE_IN;
        end else if (MEM_SRC_IN && ALIGN_EN_IN && UNALIGNED_IN && prot &&
                     (MODE_IN == udu_pkg::UDU_MD_V86 ||
                      CPL_IN == `UDU_CPL_USER)) begin
            exc_now  = udu_pkg::UDU_EX_AC;
            code_now = 1'b1;
        end else if (divisor == 32'h0) begin
            exc_now  = udu_pkg::UDU_EX_DIVIDE;
        end
    end

    // ******************************************
    // Divider iteration
    // ******************************************
    logic [63:0] step_rem;
    logic [63:0] step_quo;
    udu_restore_step u_step (
        .rem_in  (rem_q),
        .quo_in  (quo_q),
        .dvs_in  (divisor_q),
        .rem_out (step_rem),
        .quo_out (step_quo)
    );

    // Quotient width limit per size
    logic        q_over;
    always_comb begin
        unique case (size_q)
            udu_pkg::UDU_SZ_BYTE:
                q_over = quo_q > {32'h0, `UDU_BYTE_QMAX};
            udu_pkg::UDU_SZ_WORD:
                q_over = quo_q > {32'h0, `UDU_WORD_QMAX};
            default:
                q_over = quo_q[63:32] != 32'h0;
        endcase
    end

    udu_pkg::udu_exc_t exc_q,  exc_d;
    logic              hc_q,   hc_d;
    logic [15:0]       code_q, code_d;
    logic              done_q, done_d;
    logic              wr_q,   wr_d;
    logic [31:0]       acc_q,  acc_d;
    logic [31:0]       dat_q,  dat_d;

    always_comb begin
        st_d      = st_q;
        divisor_d = divisor_q;
        rem_d     = rem_q;
        quo_d     = quo_q;
        cnt_d     = cnt_q;
        size_d    = size_q;
        exc_d     = exc_q;
        hc_d      = hc_q;
        code_d    = code_q;
        done_d    = 1'b0;
        wr_d      = 1'b0;
        acc_d     = acc_q;
        dat_d     = dat_q;
        unique case (st_q)
            UDU_ST_IDLE: begin
                if (START_IN) begin
                    exc_d  = exc_now;
                    hc_d   = code_now;
                    code_d = code_val;
                    if (exc_now != udu_pkg::UDU_EX_NONE) begin
                        // fault ends the op without writeback
                        done_d = 1'b1;
                    end else begin
                        divisor_d = divisor;
                        rem_d     = 64'h0;
                        quo_d     = dividend;
                        cnt_d     = `UDU_DIV_STEPS;
                        size_d    = SIZE_IN;
                        st_d      = UDU_ST_RUN;
                    end
                end
            end
            UDU_ST_RUN: begin
                rem_d = step_rem;
                quo_d = step_quo;
                cnt_d = cnt_q - 7'h01;
                if (cnt_q == 7'h01) begin
                    st_d = UDU_ST_DONE;
                end
            end
            UDU_ST_DONE: begin
                done_d = 1'b1;
                st_d   = UDU_ST_IDLE;
                if (q_over) begin
                    exc_d = udu_pkg::UDU_EX_DIVIDE;
                    hc_d  = 1'b0;
                end else begin
                    wr_d = 1'b1;
                    unique case (size_q)
                        udu_pkg::UDU_SZ_BYTE: begin
                            acc_d = {ACC_IN[31:16], rem_q[7:0],
                                     quo_q[7:0]};
                            dat_d = DATA_IN;
                        end
                        udu_pkg::UDU_SZ_WORD: begin
                            acc_d = {ACC_IN[31:16], quo_q[15:0]};
                            dat_d = {DATA_IN[31:16], rem_q[15:0]};
                        end
                        default: begin
                            acc_d = quo_q[31:0];
                            dat_d = rem_q[31:0];
                        end
                    endcase
                end
            end
            default: st_d = UDU_ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            st_q      <= UDU_ST_IDLE;
            divisor_q <= 32'h0;
            rem_q     <= 64'h0;
            quo_q     <= 64'h0;
            cnt_q     <= 7'h00;
            size_q    <= udu_pkg::UDU_SZ_BYTE;
            exc_q     <= udu_pkg::UDU_EX_NONE;
            hc_q      <= 1'b0;
            code_q    <= 16'h0000;
            done_q    <= 1'b0;
            wr_q      <= 1'b0;
            acc_q     <= 32'h0;
            dat_q     <= 32'h0;
        end else begin
            st_q      <= st_d;
            divisor_q <= divisor_d;
            rem_q     <= rem_d;
            quo_q     <= quo_d;
            cnt_q     <= cnt_d;
            size_q    <= size_d;
            exc_q     <= exc_d;
            hc_q      <= hc_d;
            code_q    <= code_d;
            done_q    <= done_d;
            wr_q      <= wr_d;
            acc_q     <= acc_d;
            dat_q     <= dat_d;
        end
    end

    // ******************************************
    // Outputs
    // ******************************************
    assign BUSY_OUT         = (st_q != UDU_ST_IDLE);
    assign DONE_OUT         = done_q;
    assign WR_ACC_OUT       = wr_q;
    assign WR_DATA_OUT      = wr_q;
    assign ACC_OUT          = acc_q;
    assign DATA_OUT         = dat_q;
    assign FLAGS_OUT        = `UDU_FLAGS_RESULT;
    assign EXC_OUT          = done_q ? exc_q : udu_pkg::UDU_EX_NONE;
    assign EXC_HAS_CODE_OUT = done_q & hc_q;
    assign EXC_CODE_OUT     = code_q;

    // ******************************************
    // Checks
    // ******************************************
    a_zero_divides: assert property (
        (st_q == UDU_ST_IDLE && START_IN && divisor == 32'h0)
        |=> DONE_OUT && EXC_OUT != udu_pkg::UDU_EX_NONE && !WR_ACC_OUT)
        else $error("zero divisor accepted");
    a_no_write_exc: assert property (
        WR_ACC_OUT |-> EXC_OUT == udu_pkg::UDU_EX_NONE)
        else $error("write during exception");
    a_fault_fast: assert property (
        (st_q == UDU_ST_IDLE && START_IN &&
         exc_now != udu_pkg::UDU_EX_NONE) |=> DONE_OUT && !WR_ACC_OUT)
        else $error("fault not reported next cycle");
    a_div_latency: assert property (
        (st_q == UDU_ST_IDLE && START_IN &&
         exc_now == udu_pkg::UDU_EX_NONE) |-> ##66 DONE_OUT)
        else $error("divide latency wrong");
    a_byte_over: assert property (
        (st_q == UDU_ST_DONE && size_q == udu_pkg::UDU_SZ_BYTE &&
         quo_q > 64'hFF) |=> EXC_OUT == udu_pkg::UDU_EX_DIVIDE)
        else $error("byte overflow missed");
    a_rem_small: assert property (
        (st_q == UDU_ST_DONE) |-> rem_q < {32'h0, divisor_q})
        else $error("remainder not below divisor");
    a_real_nocode: assert property (
        (st_q == UDU_ST_IDLE && START_IN && MODE_IN == udu_pkg::UDU_MD_REAL)
        |=> !EXC_HAS_CODE_OUT)
        else $error("real mode fault carries code");
    a_gp_code_zero: assert property (
        (EXC_OUT == udu_pkg::UDU_EX_GP) |-> EXC_CODE_OUT == 16'h0000)
        else $error("protection fault code nonzero");
    c_ok_div: cover property (@(posedge SYS_CLK_IN) WR_ACC_OUT);
    c_de: cover property (@(posedge SYS_CLK_IN)
        EXC_OUT == udu_pkg::UDU_EX_DIVIDE);
    c_pf: cover property (@(posedge SYS_CLK_IN)
        EXC_OUT == udu_pkg::UDU_EX_PF);
endmodule

/* verif/test_unsigned_divide_unit.sv */
// Self-checking bench for the unsigned divide unit
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module test_unsigned_divide_unit;
    // ****************************************
    // Stimulus and outputs
    // ****************************************
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               start = 1'b0;
    udu_pkg::udu_size_t sz = udu_pkg::UDU_SZ_BYTE;
    udu_pkg::udu_mode_t md = udu_pkg::UDU_MD_REAL;
    logic               mem = 1'b0;
    logic [31:0]        rdvs = 32'h00000001;
    logic [31:0]        mdvs = 32'h00000001;
    logic [31:0]        acc = 32'h00000000;
    logic [31:0]        dat = 32'h00000000;
    logic               seg = 1'b0, nul = 1'b0, stk = 1'b0, pf = 1'b0;
    logic               una = 1'b0, aen = 1'b0;
    logic [15:0]        pfc = 16'h0000;
    logic [1:0]         cpl = 2'h0;
    logic               busy, done, wr_acc, wr_dat, has_code;
    logic [31:0]        acc_o, dat_o;
    logic [5:0]         flags;
    logic [15:0]        code;
    udu_pkg::udu_exc_t  exc;
    int                 errors = 0;
    int                 n_tests = 0;

    always #5 clk = ~clk;

    udu_divide_unit dut (
        .SYS_CLK_IN(clk), .RST_IN(rst), .START_IN(start), .SIZE_IN(sz),
        .MODE_IN(md), .MEM_SRC_IN(mem), .REG_DVS_IN(rdvs),
        .MEM_DVS_IN(mdvs), .ACC_IN(acc), .DATA_IN(dat),
        .SEG_LIMIT_IN(seg), .NULL_SEL_IN(nul), .STK_LIMIT_IN(stk),
        .PAGE_FAULT_IN(pf), .PF_CODE_IN(pfc), .UNALIGNED_IN(una),
        .ALIGN_EN_IN(aen), .CPL_IN(cpl), .BUSY_OUT(busy),
        .DONE_OUT(done), .WR_ACC_OUT(wr_acc), .WR_DATA_OUT(wr_dat),
        .ACC_OUT(acc_o), .DATA_OUT(dat_o), .FLAGS_OUT(flags),
        .EXC_OUT(exc), .EXC_HAS_CODE_OUT(has_code), .EXC_CODE_OUT(code));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Pulse start at a falling edge, count falling edges until done
    task automatic run(output int lat);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        lat = 1;
        while (done !== 1'b1 && lat < 200) begin
            @(negedge clk);
            lat++;
        end
        if (lat >= 200) begin
            errors++;
            $display("[FAIL] done expected 1 seen 0");
            end_sim();
        end
    endtask

    task automatic check_div(input udu_pkg::udu_size_t s,
                             input logic [31:0] a, input logic [31:0] d,
                             input logic [31:0] v, input logic m);
        logic [63:0] dd, q, r, qmax;
        logic [31:0] dv;
        logic        ovf;
        int          lat;
        q = 64'h0;
        r = 64'h0;
        dv = (s == udu_pkg::UDU_SZ_BYTE) ? {24'h0, v[7:0]} :
             (s == udu_pkg::UDU_SZ_WORD) ? {16'h0, v[15:0]} : v;
        dd = (s == udu_pkg::UDU_SZ_BYTE) ? {48'h0, a[15:0]} :
             (s == udu_pkg::UDU_SZ_WORD) ? {32'h0, d[15:0], a[15:0]} :
             {d, a};
        qmax = (s == udu_pkg::UDU_SZ_BYTE) ? 64'hFF :
               (s == udu_pkg::UDU_SZ_WORD) ? 64'hFFFF : 64'hFFFFFFFF;
        ovf = (dv == 32'h0);
        if (!ovf) begin
            q = dd / dv;
            r = dd % dv;
            ovf = (q > qmax);
        end
        sz = s;
        acc = a;
        dat = d;
        mem = m;
        // Unselected divisor differs so a wrong source shows up
        rdvs = m ? ~v : v;
        mdvs = m ? v : ~v;
        run(lat);
        `CHK("flags", 6'h00, flags)
        if (ovf) begin
            `CHK("exc", udu_pkg::UDU_EX_DIVIDE, exc)
            `CHK("wr_acc", 1'b0, wr_acc)
            `CHK("wr_data", 1'b0, wr_dat)
        end else begin
            `CHK("exc", udu_pkg::UDU_EX_NONE, exc)
            `CHK("wr_acc", 1'b1, wr_acc)
            `CHK("wr_data", 1'b1, wr_dat)
            `CHK("latency", 66, lat)
            if (s == udu_pkg::UDU_SZ_BYTE) begin
                `CHK("acc", {a[31:16], r[7:0], q[7:0]}, acc_o)
                `CHK("data", d, dat_o)
            end else if (s == udu_pkg::UDU_SZ_WORD) begin
                `CHK("acc", {a[31:16], q[15:0]}, acc_o)
                `CHK("data", {d[31:16], r[15:0]}, dat_o)
            end else begin
                `CHK("acc", q[31:0], acc_o)
                `CHK("data", r[31:0], dat_o)
            end
        end
    endtask

    // Memory byte divide with the fault inputs as set by the caller
    task automatic check_fault(input udu_pkg::udu_exc_t e,
                               input logic hc, input logic [31:0] v);
        int lat;
        sz = udu_pkg::UDU_SZ_BYTE;
        acc = 32'h00000064;
        mem = 1'b1;
        mdvs = v;
        rdvs = 32'h00000007;
        run(lat);
        `CHK("exc", e, exc)
        if (e != udu_pkg::UDU_EX_NONE) begin
            `CHK("wr_acc", 1'b0, wr_acc)
            `CHK("wr_data", 1'b0, wr_dat)
            `CHK("latency", 1, lat)
            `CHK("has_code", hc, has_code)
            if (hc) begin
                `CHK("code", (e == udu_pkg::UDU_EX_PF) ? pfc : 16'h0000,
                     code)
            end
        end
        {seg, nul, stk, pf, una, aen} = 6'h00;
        cpl = 2'h0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_byte();
        md = udu_pkg::UDU_MD_REAL;
        check_div(udu_pkg::UDU_SZ_BYTE, 32'hABCD1234, 32'h5555AAAA,
                  32'hFFFFFF56, 1'b0);
        check_div(udu_pkg::UDU_SZ_BYTE, 32'h00000FFF, 32'h0, 32'h10,
                  1'b1);
        check_div(udu_pkg::UDU_SZ_BYTE, 32'h00001000, 32'h0, 32'h10,
                  1'b0);
        $display("Test byte done");
    endtask

    task automatic t_word();
        md = udu_pkg::UDU_MD_PROT;
        check_div(udu_pkg::UDU_SZ_WORD, 32'h9ABC5678, 32'h77771234,
                  32'h0000ABCD, 1'b1);
        check_div(udu_pkg::UDU_SZ_WORD, 32'h0000FFFF, 32'h0000000F,
                  32'h10, 1'b0);
        check_div(udu_pkg::UDU_SZ_WORD, 32'h0, 32'h00000010, 32'h10,
                  1'b1);
        $display("Test word done");
    endtask

    task automatic t_dword();
        md = udu_pkg::UDU_MD_V86;
        check_div(udu_pkg::UDU_SZ_DWORD, 32'h89ABCDEF, 32'h01234567,
                  32'h87654321, 1'b0);
        check_div(udu_pkg::UDU_SZ_DWORD, 32'hFFFFFFFF, 32'hFFFFFFFE,
                  32'hFFFFFFFF, 1'b1);
        check_div(udu_pkg::UDU_SZ_DWORD, 32'h0, 32'h5, 32'h5, 1'b0);
        $display("Test dword done");
    endtask

    task automatic t_zero();
        for (int i = 0; i < 3; i++) begin
            md = udu_pkg::udu_mode_t'(i);
            check_div(udu_pkg::UDU_SZ_DWORD, 32'h1, 32'h0, 32'h0,
                      i[0]);
        end
        $display("Test zero divisor done");
    endtask

    task automatic t_faults();
        md = udu_pkg::UDU_MD_PROT;
        seg = 1'b1;
        check_fault(udu_pkg::UDU_EX_GP, 1'b1, 32'h5);
        nul = 1'b1;
        check_fault(udu_pkg::UDU_EX_GP, 1'b1, 32'h5);
        stk = 1'b1;
        check_fault(udu_pkg::UDU_EX_SS, 1'b1, 32'h5);
        pf = 1'b1;
        pfc = 16'h01A5;
        check_fault(udu_pkg::UDU_EX_PF, 1'b1, 32'h5);
        {una, aen, cpl} = {1'b1, 1'b1, 2'h3};
        check_fault(udu_pkg::UDU_EX_AC, 1'b1, 32'h5);
        {una, aen, cpl} = {1'b1, 1'b1, 2'h0};
        check_fault(udu_pkg::UDU_EX_NONE, 1'b0, 32'h5);
        {seg, stk} = 2'b11;
        check_fault(udu_pkg::UDU_EX_GP, 1'b1, 32'h0);
        md = udu_pkg::UDU_MD_REAL;
        seg = 1'b1;
        check_fault(udu_pkg::UDU_EX_GP, 1'b0, 32'h5);
        nul = 1'b1;
        check_fault(udu_pkg::UDU_EX_GP, 1'b0, 32'h5);
        stk = 1'b1;
        check_fault(udu_pkg::UDU_EX_SS, 1'b0, 32'h5);
        md = udu_pkg::UDU_MD_V86;
        pf = 1'b1;
        check_fault(udu_pkg::UDU_EX_PF, 1'b1, 32'h5);
        {una, aen} = 2'b11;
        check_fault(udu_pkg::UDU_EX_AC, 1'b1, 32'h5);
        nul = 1'b1;
        check_fault(udu_pkg::UDU_EX_NONE, 1'b0, 32'h5);
        $display("Test faults done");
    endtask

    // A start while busy must not spawn a second result
    task automatic t_busy();
        int lat;
        int extra;
        md = udu_pkg::UDU_MD_PROT;
        sz = udu_pkg::UDU_SZ_BYTE;
        acc = 32'h000003E8;
        mem = 1'b0;
        rdvs = 32'h00000007;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (10) @(negedge clk);
        `CHK("busy", 1'b1, busy)
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        lat = 12;
        while (done !== 1'b1 && lat < 200) begin
            @(negedge clk);
            lat++;
        end
        `CHK("latency", 66, lat)
        if (lat >= 200) end_sim();
        `CHK("acc", 32'h0000068E, acc_o)
        extra = 0;
        repeat (70) begin
            @(negedge clk);
            if (done === 1'b1) extra++;
        end
        `CHK("extra done", 0, extra)
        $display("Test busy refusal done");
    endtask

    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        `CHK("done", 1'b0, done)
        `CHK("exc", udu_pkg::UDU_EX_NONE, exc)
        `CHK("busy", 1'b0, busy)
        t_byte();
        t_word();
        t_dword();
        t_zero();
        t_faults();
        t_busy();
        end_sim();
    end
endmodule
